// ===== serial_pin_route_select_tb.sv
// Purpose: register and routing tests of the serial pin route select block
// Assumes: one clock, reads answer one cycle after the strobe
// Notes: every pair, group, swap and timer code is walked with two pad patterns
`timescale 1ns/1ps
module serial_pin_route_select_tb;
  localparam logic [11:0] RS = sprs_pkg::ADDR_SERIAL_ROUTE_SELECT;
  localparam logic [11:0] SW = sprs_pkg::ADDR_UART_PIN_SWAP;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [11:0] pad = 12'h000;
  logic [11:0] pat = 12'h000;
  logic run = 1'b0;
  logic [6:0] uo;
  logic [3:0] irq;
  logic [5:0] p2o;
  logic [5:0] p2s;
  logic [2:0] pbo;
  logic [5:0] p2e;
  logic [2:0] pbe;
  logic [2:0] pbs;
  logic [1:0] p9o;
  logic [1:0] p9e;
  logic sck;
  logic tck;
  wire [10:0] o;
  int fails = 0;
  int n_tests = 0;
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  sprs_far u_sprs_far (.run(run), .pat(pat), .unit_out(uo), .irq(irq));
  sprs_route u_sprs_route (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port2_in_bit0(pad[0]), .port2_in_bit1(pad[1]), .port2_in_bit2(pad[2]),
    .port2_in_bit3(pad[3]), .port2_in_bit4(pad[4]), .port2_in_bit5(pad[5]),
    .port7_in_bit2(pad[6]), .port9_in_bit0(pad[7]), .port9_in_bit1(pad[8]),
    .portb_in_bit4(pad[9]), .portb_in_bit5(pad[10]), .portb_in_bit6(pad[11]),
    .port2_fn_out(p2o), .port2_fn_oe(p2e), .port2_fn_sel(p2s), .port9_fn_out(p9o),
    .port9_fn_oe(p9e), .portb_fn_out(pbo), .portb_fn_oe(pbe), .portb_fn_sel(pbs),
    .item_a_tx(uo[0]), .item_a_rx(o[0]),
    .item_a_enable(o[5]), .item_b_tx(uo[1]), .item_b_rx(o[1]), .sync_data_out(uo[2]),
    .sync_clock_out(uo[3]), .sync_clock_oe(uo[4]), .sync_data_in(o[2]), .sync_clock_in(sck),
    .sync_enable(o[6]), .two_wire_data_oe(uo[5]), .two_wire_clock_oe(uo[6]),
    .two_wire_data_in(o[3]), .two_wire_clock_in(tck), .two_wire_enable(o[7]),
    .timer_a0_input(o[4]), .item_a_transmit_interrupt(irq[0]), .item_a_receive_interrupt(irq[1]),
    .sync_serial0_interrupt(irq[2]), .two_wire0_interrupt(irq[3]), .latch7_set(o[8]),
    .latch6_set(o[9]), .latch15_set(o[10]));
  task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp({3'b000, reg_rdata}, {3'b000, exp});
    @(posedge clk_sys);
  endtask : rd
  task automatic scen(input logic [4:0] r);
    logic [1:0] p;
    logic g;
    logic [10:0] e;
    logic [2:0] tx;
    logic [2:0] t;
    logic [10:0] f;
    p = r[1:0];
    g = r[2];
    run <= 1'b0;
    @(posedge clk_sys);
    wr(RS, {p, 1'b0, g, 2'b00, p});
    wr(SW, {6'h00, r[4:3]});
    run <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      pad <= k ? 12'h4D5 : 12'hB2A;
      pat <= k ? 12'h5B6 : 12'hA49;
      @(posedge clk_sys);
      #1;
      e[0] = p[1] ? 1'b1 : (r[3] ? pad[g ? 9 : 0] : pad[g ? 10 : 1]);
      e[1] = r[4] ? pad[7] : pad[8];
      e[2] = p == 2'b01 ? pad[4] : p == 2'b10 ? pad[g ? 10 : 1] : 1'b0;
      e[3] = (p == 2'b00 || p == 2'b10) ? pad[3] : 1'b1;
      e[4] = p == 2'b00 ? pad[6] : p == 2'b01 ? pad[1] : p == 2'b10 ? pad[8] : 1'b0;
      e[7:5] = p == 2'b00 ? 3'b101 : p == 2'b01 ? 3'b011 : p == 2'b10 ? 3'b110 : 3'b000;
      e[8] = p[1] ? 1'b0 : pat[8];
      e[9] = p[1] ? (p[0] ? 1'b0 : pat[10]) : pat[9];
      e[10] = p == 2'b01 ? pat[10] : p == 2'b11 ? 1'b0 : pat[11];
      cmp(o, e);
      tx = g ? pbo : p2o[2:0];
      if (!p[1])
        cmp({10'h000, tx[r[3]]}, {10'h000, pat[0]});
      if (p == 2'b10)
        cmp({9'h000, tx[2], tx[0]}, {9'h000, pat[3], pat[2]});
      if (p == 2'b01)
        cmp({9'h000, p2o[5], p2o[3]}, {9'h000, pat[3], pat[2]});
      cmp({10'h000, p9o[r[4]]}, {10'h000, pat[1]});
      cmp({10'h000, p2s[5]}, {10'h000, p == 2'b01});
      // Drive enables show which trio pin item_a transmits on, so swaps are visible
      t = p[1] ? (p[0] ? 3'b000 : {pat[4], 2'b01}) : (r[3] ? 3'b010 : 3'b001);
      f[10:8] = p == 2'b01 ? {pat[4], 2'b01} : (p[0] ? 3'b000 : {1'b0, pat[6], pat[5]});
      f[7:0] = {g ? 3'b000 : t, g ? t : 3'b000, r[4] ? 2'b10 : 2'b01};
      cmp({p2e, pbe, p9e}, f);
      t = p[1] ? (p[0] ? 3'b000 : 3'b111) : 3'b011;
      f[10:8] = p == 2'b01 ? 3'b111 : (p[0] ? 3'b000 : 3'b011);
      f[7:2] = {g ? 3'b000 : t, g ? t : 3'b000};
      f[1] = p == 2'b01 ? pad[5] : p == 2'b10 ? pad[g ? 11 : 2] : 1'b0;
      f[0] = p[0] ? 1'b1 : pad[4];
      cmp({p2s, pbs, sck, tck}, f);
      @(posedge clk_sys);
    end
  endtask : scen
  task automatic stop_test;
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(RS, 8'h00);
    rd(SW, 8'h00);
    wr(RS, 8'hFF);
    rd(RS, 8'hD3);
    wr(SW, 8'hFF);
    rd(SW, 8'h03);
    wr(12'h123, 8'hFF);
    rd(12'h123, 8'h00);
    for (int r = 0; r < 32; r++)
      scen(r[4:0]);
    // Reset again with both registers loaded
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(RS, 8'h00);
    rd(SW, 8'h00);
    stop_test();
  end
endmodule : serial_pin_route_select_tb

// ===== sprs_chk.sv
// Purpose: port-level checks of the serial pin route select block
// Assumes: register writes are seen at the port, so shadows track the fields
// Notes: routing checks use the shadow copies, never internal state
`timescale 1ns/1ps
module sprs_chk
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Routed signals
  input wire logic port2_in_bit3,
  input wire logic port9_in_bit0,
  input wire logic port9_in_bit1,
  input wire logic item_b_rx,
  input wire logic item_a_enable,
  input wire logic sync_enable,
  input wire logic two_wire_enable,
  input wire logic two_wire_data_in,
  input wire logic timer_a0_input,
  input wire logic sync_serial0_interrupt,
  input wire logic latch6_set,
  input wire logic latch7_set,
  input wire logic latch15_set
);
  logic [7:0] rs;
  logic [7:0] sw;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rs <= 8'h00;
      sw <= 8'h00;
    end
    else if (reg_wr && reg_addr == sprs_pkg::ADDR_SERIAL_ROUTE_SELECT)
      rs <= reg_wdata & sprs_pkg::MASK_SERIAL_ROUTE_SELECT;
    else if (reg_wr && reg_addr == sprs_pkg::ADDR_UART_PIN_SWAP)
      sw <= reg_wdata & sprs_pkg::MASK_UART_PIN_SWAP;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_tmr; rs[7:6] == 2'b10 |-> timer_a0_input == port9_in_bit1;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer input not on port9 bit1");
  property p_rsv; rs[1:0] == 2'b11 |-> !(item_a_enable || sync_enable || two_wire_enable);
  endproperty
  a_rsv: assert property (p_rsv) else $error("unit enabled by reserved pair");
  property p_en0; rs[1:0] == 2'b00 |-> item_a_enable && two_wire_enable && !sync_enable;
  endproperty
  a_en0: assert property (p_en0) else $error("wrong units for pair 00");
  property p_two; !(item_a_enable && sync_enable && two_wire_enable);
  endproperty
  a_two: assert property (p_two) else $error("three units enabled");
  property p_l15; rs[1:0] == 2'b01 |-> latch15_set == sync_serial0_interrupt;
  endproperty
  a_l15: assert property (p_l15) else $error("latch15 not sync serial");
  property p_l6; rs[1:0] == 2'b10 |-> latch6_set == sync_serial0_interrupt && !latch7_set;
  endproperty
  a_l6: assert property (p_l6) else $error("latch6 not sync serial");
  property p_sw1; sw[1] |-> item_b_rx == port9_in_bit0;
  endproperty
  a_sw1: assert property (p_sw1) else $error("swapped receive not on port9 bit0");
  property p_tw; two_wire_enable |-> two_wire_data_in == port2_in_bit3;
  endproperty
  a_tw: assert property (p_tw) else $error("two-wire data not on port2 bit3");
  property p_rd;
    reg_rd && reg_addr == sprs_pkg::ADDR_SERIAL_ROUTE_SELECT |=> reg_rdata == $past(rs);
  endproperty
  a_rd: assert property (p_rd) else $error("route select read mismatch");
  property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside read cycle");
endmodule : sprs_chk
bind sprs_route sprs_chk u_sprs_chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .port2_in_bit3, .port9_in_bit0, .port9_in_bit1, .item_b_rx, .item_a_enable,
  .sync_enable, .two_wire_enable, .two_wire_data_in, .timer_a0_input, .sync_serial0_interrupt,
  .latch6_set, .latch7_set, .latch15_set);

// ===== sprs_far.sv
// Purpose: model of the serial units' outputs and requests facing the router
// Assumes: run low means every unit and the timer are stopped
// Notes: stopped units idle with uart lines high and no requests
`timescale 1ns/1ps
module sprs_far
(
  // Bench control
  input wire logic run,
  input wire logic [11:0] pat,
  // Unit outputs toward the router
  output logic [6:0] unit_out,
  output logic [3:0] irq
);
  // Routing only changes while this model reports the units stopped, except at the bench's second reset
  assign unit_out = run ? pat[6:0] : 7'h03;
  // No requests while register writes move routing, so no shared latch holds a stale source
  assign irq = run ? pat[11:8] : 4'h0;
endmodule : sprs_far

// ===== sprs_pkg.sv
// Purpose: constants for the serial pin route select block
// Assumes: byte-wide register port, one clock, synchronous reset
// Notes: pin and interrupt routing is purely combinational from the two registers
//
// Notes on behaviour
// R01 - The timer input field picks port7_bit2 (00), port2_bit1 (01) or port9_bit1 (10); 11 is reserved.
// R02 - The port group bit puts item_a and sync serial pins on port2 bits 0-2 when 0, portb bits 4-6 when 1.
// R03 - The pair field enables item_a+two-wire (00), item_a+sync (01), sync+two-wire (10); 11 reserved.
// R04 - At most two of the three serial units reach pins and interrupts at once.
// R05 - item_b receive is port9_bit1 and transmit port9_bit0, exchanged when its swap bit is 1.
// R06 - item_a receive/transmit use port2_bit1/bit0 or portb_bit5/bit4 by group, exchanged when swapped.
// R07 - Software changes the routing register only while the affected units and timer are stopped.
// R08 - Software changes the swap register only while the affected uarts are stopped.
// R09 - Software should clear the affected interrupt latch right after changing the routing register.
// R10 - One latch is shared by uart receive and sync serial, one by two-wire and sync serial.
// R11 - Latches 7/6/15 carry tx/rx/two-wire (00), tx/rx/sync (01), none/sync/two-wire (10).
// R12 - In the sync+two-wire pair sync out/in/clock use port2 bits 0-2 or portb bits 4-6 by group.
// R13 - In the item_a+sync pair sync out/in/clock use port2 bits 3-5 regardless of group.
// R14 - A selected two-wire unit has data on port2_bit3 and clock on port2_bit4.
// R15 - Pins not given a serial function act as general ports; software clears their function bit.
// R16 - Unused bits read zero and ignore writes; writable fields reset to zero.
package sprs_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ADDR_UART_PIN_SWAP = 12'hF57;
  localparam logic [11:0] ADDR_SERIAL_ROUTE_SELECT = 12'hFCB;
  localparam logic [7:0] RESET_UART_PIN_SWAP = 8'h00;
  localparam logic [7:0] RESET_SERIAL_ROUTE_SELECT = 8'h00;
  // Field positions
  localparam int TIMER_SEL_LSB = 6;
  localparam int GROUP_SEL_BIT = 4;
  localparam int PAIR_SEL_LSB = 0;
  localparam int ITEM_A_SWAP_BIT = 0;
  localparam int ITEM_B_SWAP_BIT = 1;
  // Writable bit masks
  localparam logic [7:0] MASK_SERIAL_ROUTE_SELECT = 8'hD3;
  localparam logic [7:0] MASK_UART_PIN_SWAP = 8'h03;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0]
  {
    SPRS_PAIR_A_TW = 2'b00,
    SPRS_PAIR_A_SY = 2'b01,
    SPRS_PAIR_SY_TW = 2'b10,
    SPRS_PAIR_RSVD = 2'b11
  } sprs_pair_t;

  typedef enum logic [1:0]
  {
    SPRS_TMR_P72 = 2'b00,
    SPRS_TMR_P21 = 2'b01,
    SPRS_TMR_P91 = 2'b10,
    SPRS_TMR_RSVD = 2'b11
  } sprs_tmr_t;
endpackage : sprs_pkg

// ===== sprs_regs.sv
// Purpose: register pair of the serial pin route select block
// Assumes: strobes one cycle long, never together
// Notes: read data valid the cycle after the read strobe only
`timescale 1ns/1ps
module sprs_regs
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Field outputs
  output logic [7:0] route_sel,
  output logic [7:0] swap_sel
);

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      route_sel <= sprs_pkg::RESET_SERIAL_ROUTE_SELECT; // R16
    else if (reg_wr && reg_addr == sprs_pkg::ADDR_SERIAL_ROUTE_SELECT)
      route_sel <= reg_wdata & sprs_pkg::MASK_SERIAL_ROUTE_SELECT; // R16
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      swap_sel <= sprs_pkg::RESET_UART_PIN_SWAP; // R16
    else if (reg_wr && reg_addr == sprs_pkg::ADDR_UART_PIN_SWAP)
      swap_sel <= reg_wdata & sprs_pkg::MASK_UART_PIN_SWAP; // R16
  end

  // Unmapped addresses read zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == sprs_pkg::ADDR_SERIAL_ROUTE_SELECT)
      reg_rdata <= route_sel;
    else if (reg_rd && reg_addr == sprs_pkg::ADDR_UART_PIN_SWAP)
      reg_rdata <= swap_sel;
    else
      reg_rdata <= 8'h00;
  end
endmodule : sprs_regs

// ===== sprs_route.sv
// Purpose: routes serial unit pins, timer capture input and shared interrupt latches
// Assumes: pin inputs synchronous to clk_sys; port logic merges the serial enables
// Notes: reserved codes connect nothing, so all affected pins fall back to ports
`timescale 1ns/1ps
module sprs_route
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pin inputs from pads
  input wire logic port2_in_bit0,
  input wire logic port2_in_bit1,
  input wire logic port2_in_bit2,
  input wire logic port2_in_bit3,
  input wire logic port2_in_bit4,
  input wire logic port2_in_bit5,
  input wire logic port7_in_bit2,
  input wire logic port9_in_bit0,
  input wire logic port9_in_bit1,
  input wire logic portb_in_bit4,
  input wire logic portb_in_bit5,
  input wire logic portb_in_bit6,
  // Serial function drive toward pads: value and enable
  output logic [5:0] port2_fn_out,
  output logic [5:0] port2_fn_oe,
  output logic [5:0] port2_fn_sel,
  output logic [1:0] port9_fn_out,
  output logic [1:0] port9_fn_oe,
  output logic [2:0] portb_fn_out,
  output logic [2:0] portb_fn_oe,
  output logic [2:0] portb_fn_sel,
  // item_a
  input wire logic item_a_tx,
  output logic item_a_rx,
  output logic item_a_enable,
  // item_b
  input wire logic item_b_tx,
  output logic item_b_rx,
  // Sync serial unit
  input wire logic sync_data_out,
  input wire logic sync_clock_out,
  input wire logic sync_clock_oe,
  output logic sync_data_in,
  output logic sync_clock_in,
  output logic sync_enable,
  // Two-wire unit, open drain: oe high pulls line low
  input wire logic two_wire_data_oe,
  input wire logic two_wire_clock_oe,
  output logic two_wire_data_in,
  output logic two_wire_clock_in,
  output logic two_wire_enable,
  // Timer
  output logic timer_a0_input,
  // Interrupt requests and latch sets
  input wire logic item_a_transmit_interrupt,
  input wire logic item_a_receive_interrupt,
  input wire logic sync_serial0_interrupt,
  input wire logic two_wire0_interrupt,
  output logic latch7_set,
  output logic latch6_set,
  output logic latch15_set
);

  logic [7:0] route_sel;
  logic [7:0] swap_sel;
  sprs_pkg::sprs_pair_t pair;
  sprs_pkg::sprs_tmr_t tmr;
  logic grp;
  logic sw0;
  logic sw1;
  logic a_on;
  logic s_on;
  logic t_on;
  logic s_low;
  logic [2:0] trio_out;
  logic [2:0] trio_oe;
  logic [2:0] trio_in;

  // ****************************************
  // Registers
  // ****************************************
  sprs_regs u_regs
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .route_sel(route_sel),
    .swap_sel(swap_sel)
  );

  // ****************************************
  // Field decode
  // ****************************************
  // Changing fields mid-transfer glitches pins; software stops units first
  assign pair = sprs_pkg::sprs_pair_t'(route_sel[sprs_pkg::PAIR_SEL_LSB +: 2]); // R03 R07
  assign tmr = sprs_pkg::sprs_tmr_t'(route_sel[sprs_pkg::TIMER_SEL_LSB +: 2]);
  assign grp = route_sel[sprs_pkg::GROUP_SEL_BIT]; // R02
  assign sw0 = swap_sel[sprs_pkg::ITEM_A_SWAP_BIT]; // R08
  assign sw1 = swap_sel[sprs_pkg::ITEM_B_SWAP_BIT];

  always_comb
  begin
    a_on = 1'b0;
    s_on = 1'b0;
    t_on = 1'b0;
    case (pair) // R03 R04
      sprs_pkg::SPRS_PAIR_A_TW:
      begin
        a_on = 1'b1;
        t_on = 1'b1;
      end
      sprs_pkg::SPRS_PAIR_A_SY:
      begin
        a_on = 1'b1;
        s_on = 1'b1;
      end
      sprs_pkg::SPRS_PAIR_SY_TW:
      begin
        s_on = 1'b1;
        t_on = 1'b1;
      end
      default:
      begin
        a_on = 1'b0;
      end
    endcase
  end

  assign item_a_enable = a_on;
  assign sync_enable = s_on;
  assign two_wire_enable = t_on;
  // Sync serial sits on the group trio only when item_a is absent
  assign s_low = s_on && !a_on; // R12 R13

  // ****************************************
  // Group trio: item_a or low-side sync serial
  // ****************************************
  always_comb
  begin
    trio_out = 3'b000;
    trio_oe = 3'b000;
    if (a_on)
    begin
      // Bit 0 carries tx unless swapped, bit 1 the other way
      trio_out = {1'b0, item_a_tx, item_a_tx}; // R06
      trio_oe = sw0 ? 3'b010 : 3'b001; // R06
    end
    else if (s_low)
    begin
      trio_out = {sync_clock_out, 1'b0, sync_data_out}; // R12
      trio_oe = {sync_clock_oe, 1'b0, 1'b1}; // R12
    end
  end

  assign trio_in = grp ? {portb_in_bit6, portb_in_bit5, portb_in_bit4}
                       : {port2_in_bit2, port2_in_bit1, port2_in_bit0}; // R02

  always_comb
  begin
    port2_fn_out = 6'h00;
    port2_fn_oe = 6'h00;
    port2_fn_sel = 6'h00;
    portb_fn_out = trio_out;
    portb_fn_oe = 3'b000;
    portb_fn_sel = 3'b000;
    if (grp) // R02
    begin
      portb_fn_oe = trio_oe;
      portb_fn_sel = a_on ? 3'b011 : (s_low ? 3'b111 : 3'b000); // R15
    end
    else
    begin
      port2_fn_out[2:0] = trio_out;
      port2_fn_oe[2:0] = trio_oe;
      port2_fn_sel[2:0] = a_on ? 3'b011 : (s_low ? 3'b111 : 3'b000); // R15
    end
    if (t_on) // R14
    begin
      port2_fn_oe[3] = two_wire_data_oe;
      port2_fn_oe[4] = two_wire_clock_oe;
      port2_fn_sel[4:3] = 2'b11;
    end
    else if (s_on && a_on) // R13
    begin
      port2_fn_out[5:3] = {sync_clock_out, 1'b0, sync_data_out};
      port2_fn_oe[5:3] = {sync_clock_oe, 1'b0, 1'b1};
      port2_fn_sel[5:3] = 3'b111;
    end
  end

  // ****************************************
  // Inputs toward the units
  // ****************************************
  assign item_a_rx = a_on ? (sw0 ? trio_in[0] : trio_in[1]) : 1'b1; // R06
  assign sync_data_in = s_low ? trio_in[1] : (s_on ? port2_in_bit4 : 1'b0); // R12 R13
  assign sync_clock_in = s_low ? trio_in[2] : (s_on ? port2_in_bit5 : 1'b0); // R12 R13
  assign two_wire_data_in = t_on ? port2_in_bit3 : 1'b1; // R14
  assign two_wire_clock_in = t_on ? port2_in_bit4 : 1'b1; // R14

  // ****************************************
  // item_b pins
  // ****************************************
  assign item_b_rx = sw1 ? port9_in_bit0 : port9_in_bit1; // R05
  assign port9_fn_out = {item_b_tx, item_b_tx};
  assign port9_fn_oe = sw1 ? 2'b10 : 2'b01; // R05

  // ****************************************
  // Timer capture input
  // ****************************************
  always_comb
  begin
    case (tmr) // R01
      sprs_pkg::SPRS_TMR_P72: timer_a0_input = port7_in_bit2;
      sprs_pkg::SPRS_TMR_P21: timer_a0_input = port2_in_bit1;
      sprs_pkg::SPRS_TMR_P91: timer_a0_input = port9_in_bit1;
      default: timer_a0_input = 1'b0;
    endcase
  end

  // ****************************************
  // Shared interrupt latches
  // ****************************************
  // Sources share latches, so stale requests are ambiguous after a switch
  always_comb
  begin
    latch7_set = 1'b0;
    latch6_set = 1'b0;
    latch15_set = 1'b0;
    case (pair) // R10 R11 R09
      sprs_pkg::SPRS_PAIR_A_TW:
      begin
        latch7_set = item_a_transmit_interrupt;
        latch6_set = item_a_receive_interrupt;
        latch15_set = two_wire0_interrupt;
      end
      sprs_pkg::SPRS_PAIR_A_SY:
      begin
        latch7_set = item_a_transmit_interrupt;
        latch6_set = item_a_receive_interrupt;
        latch15_set = sync_serial0_interrupt;
      end
      sprs_pkg::SPRS_PAIR_SY_TW:
      begin
        latch6_set = sync_serial0_interrupt;
        latch15_set = two_wire0_interrupt;
      end
      default:
      begin
        latch7_set = 1'b0;
      end
    endcase
  end
endmodule : sprs_route
